// File: src/uspm_pkg.sv
// Constants for the serial and modem pin block
package uspm_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned BAUD_DEFAULT = 115_200;
  localparam int unsigned CLKS_PER_BIT_DEFAULT = CLK_HZ / BAUD_DEFAULT;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned LEVEL_W = 7;
  // Byte addresses of the word registers
  localparam logic [4:0] OFS_TX_DATA = 5'h00;
  localparam logic [4:0] OFS_MODEM_CTRL = 5'h04;
  localparam logic [4:0] OFS_MODEM_STAT = 5'h08;
  localparam logic [4:0] OFS_INT_EN = 5'h0C;
  localparam logic [4:0] OFS_RX_TRIG = 5'h10;
  localparam logic [4:0] OFS_LINE_STAT = 5'h14;
  // Modem control bits
  localparam int unsigned MC_DTR = 0;
  localparam int unsigned MC_RTS = 1;
  localparam int unsigned MC_LOOP = 4;
  localparam int unsigned MC_AUTO_FLOW = 5;
  localparam int unsigned MC_IR = 6;
  localparam logic [7:0] MC_RESET = 8'h00;
  localparam logic [7:0] MC_MASK = 8'h73;
  // Modem status bits
  localparam int unsigned MS_DCTS = 0;
  localparam int unsigned MS_DDSR = 1;
  localparam int unsigned MS_CTS = 4;
  localparam int unsigned MS_DSR = 5;
  // Interrupt enable bit for modem status
  localparam int unsigned IE_MODEM = 3;
  localparam logic [6:0] RX_TRIG_RESET = 7'h08;
  // Line status bits
  localparam int unsigned LS_TX_BUSY = 0;
  localparam int unsigned LS_RX_LINE = 1;
  localparam int unsigned LS_TX_LINE = 2;
  localparam int unsigned BITS_PER_CHAR = 8;
  // Infrared pulse length as a divisor of the bit time
  localparam int unsigned IR_PULSE_DIV = 4;
endpackage

// File: src/uspm_tx_if.sv
// Link between the register side and the character transmitter
`timescale 1ns/1ps
interface uspm_tx_if;
  logic start;
  logic [7:0] data;
  logic ir_mode;
  logic ready;
  logic line;
  modport ctl (output start, output data, output ir_mode,
               input ready, input line);
  modport tx (input start, input data, input ir_mode,
              output ready, output line);
endinterface

// File: src/uspm_tx.sv
// Character serialiser with normal and infrared line coding
`timescale 1ns/1ps
module uspm_tx #(
  parameter int unsigned CLKS_PER_BIT = uspm_pkg::CLKS_PER_BIT_DEFAULT
) (
  input wire logic clk,
  input wire logic rst,
  uspm_tx_if.tx ifc
);
  initial
  begin
    if (CLKS_PER_BIT < uspm_pkg::IR_PULSE_DIV)
      $error("CLKS_PER_BIT too small");
  end

  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_START = 4'b0010,
    S_DATA = 4'b0100,
    S_STOP = 4'b1000
  } uspm_txst_t;

  localparam int unsigned CW = $clog2(CLKS_PER_BIT + 1);
  localparam logic [CW-1:0] BIT_LAST = CW'(CLKS_PER_BIT - 1);
  localparam logic [CW-1:0] IR_LEN =
    CW'(CLKS_PER_BIT / uspm_pkg::IR_PULSE_DIV);

  uspm_txst_t state_q, state_d;
  logic [CW-1:0] cnt_q;
  logic [2:0] bitn_q;
  logic [7:0] shift_q;
  logic line_q;
  logic bit_end;
  logic cur_bit;
  logic line_d;

  assign bit_end = cnt_q == BIT_LAST;
  assign ifc.ready = state_q == S_IDLE;
  assign ifc.line = line_q;
  assign cur_bit = (state_q == S_DATA) ? shift_q[0] :
                   (state_q == S_START) ? 1'b0 : 1'b1;
  // Infrared: a zero bit is a short high pulse, the line otherwise low
  assign line_d = ifc.ir_mode ? (~cur_bit & (cnt_q < IR_LEN)) : cur_bit;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_IDLE: if (ifc.start) state_d = S_START;
      S_START: if (bit_end) state_d = S_DATA;
      S_DATA:
        if (bit_end && bitn_q == 3'(uspm_pkg::BITS_PER_CHAR - 1))
          state_d = S_STOP;
      S_STOP: if (bit_end) state_d = S_IDLE;
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      bitn_q <= 3'h0;
      shift_q <= 8'h00;
      line_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= (state_q == S_IDLE || bit_end) ? '0 : cnt_q + 1'b1;
      if (state_q == S_IDLE && ifc.start)
        shift_q <= ifc.data;
      else if (state_q == S_DATA && bit_end)
        shift_q <= {1'b0, shift_q[7:1]};
      if (state_q == S_DATA && bit_end)
        bitn_q <= bitn_q + 3'h1;
      line_q <= line_d; // RQ1 RQ2
    end
  end
endmodule // uspm_tx

// File: src/uart_serial_modem_pins.sv
// Serial line and modem handshake pins of one channel, Avalon-MM slave
// Function
// [RQ1] Transmit line idles high in normal mode
// [RQ2] Infrared select makes transmit line idle low
// [RQ3] Reset always starts in normal signalling
// [RQ4] Partner idles receive line high normally
// [RQ5] Partner idles receive line low in infrared
// [RQ6] Control bit one drives request-to-send low
// [RQ7] Auto flow drives request-to-send from level
// [RQ8] Request-to-send high after reset and idle
// [RQ9] Loopback forces both handshake outputs high
// [RQ10] Control bit zero drives terminal-ready low
// [RQ11] Terminal-ready high after reset and idle
// [RQ12] Status bit four is inverted clear-to-send
// [RQ13] Status bit zero flags clear-to-send change
// [RQ14] Clear-to-send change raises enabled interrupt
// [RQ15] Clear-to-send gates transmitter under auto flow
// [RQ16] Status bit five is inverted set-ready
// [RQ17] Status bit one flags set-ready change
// [RQ18] Set-ready change raises enabled interrupt
// [RQ19] Reading status clears change flags
// [RQ20] Auto flow finishes character, starts none
//
// The Avalon-MM slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module uart_serial_modem_pins #(
  parameter int unsigned CLKS_PER_BIT = uspm_pkg::CLKS_PER_BIT_DEFAULT
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [uspm_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [uspm_pkg::DATA_W-1:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [uspm_pkg::DATA_W-1:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic SERIAL_TX_OUT,
  input wire logic SERIAL_RX_IN,
  output logic RTS_N,
  output logic DTR_N,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic [uspm_pkg::LEVEL_W-1:0] RX_FIFO_LEVEL,
  output logic MODEM_IRQ
);
  initial
  begin
    if (CLKS_PER_BIT < uspm_pkg::IR_PULSE_DIV)
      $error("CLKS_PER_BIT too small");
    // Level compare and trigger register share one width
    if (uspm_pkg::LEVEL_W != $bits(uspm_pkg::RX_TRIG_RESET))
      $error("LEVEL_W does not match the trigger register");
    // Every register lives in the low byte of a word
    if (uspm_pkg::DATA_W < 8)
      $error("DATA_W too small");
    if (uspm_pkg::ADDR_W != $bits(uspm_pkg::OFS_TX_DATA))
      $error("ADDR_W does not match the register offsets");
  end

  // Pin synchronisers; first stages feed only the second stages
  // Reset to the inactive level, so release shows no false change
  logic cts_n_m_q, cts_n_s_q;
  logic dsr_n_m_q, dsr_n_s_q;
  logic rx_m_q, rx_s_q;

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cts_n_m_q <= 1'b1;
      cts_n_s_q <= 1'b1;
      dsr_n_m_q <= 1'b1;
      dsr_n_s_q <= 1'b1;
      rx_m_q <= 1'b1;
      rx_s_q <= 1'b1;
    end
    else
    begin
      cts_n_m_q <= CTS_N;
      cts_n_s_q <= cts_n_m_q;
      dsr_n_m_q <= DSR_N;
      dsr_n_s_q <= dsr_n_m_q;
      rx_m_q <= SERIAL_RX_IN;
      rx_s_q <= rx_m_q;
    end
  end

  // Bus handshake: one wait state on every access
  // Read data is caught in the wait cycle and stands at acceptance
  logic ack_q;
  logic req;
  logic accept;
  logic wr_acc;
  logic rd_acc;

  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign accept = req & ack_q;
  assign wr_acc = accept & AVS_WRITE & AVS_BYTEENABLE[0];
  assign rd_acc = accept & AVS_READ;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
    hit = a == o;
  endfunction

  wire sel_tx = hit(AVS_ADDRESS, uspm_pkg::OFS_TX_DATA);
  wire sel_mc = hit(AVS_ADDRESS, uspm_pkg::OFS_MODEM_CTRL);
  wire sel_ms = hit(AVS_ADDRESS, uspm_pkg::OFS_MODEM_STAT);
  wire sel_ie = hit(AVS_ADDRESS, uspm_pkg::OFS_INT_EN);
  wire sel_tg = hit(AVS_ADDRESS, uspm_pkg::OFS_RX_TRIG);
  wire sel_ls = hit(AVS_ADDRESS, uspm_pkg::OFS_LINE_STAT);
  wire wr_mc = wr_acc & sel_mc;
  wire wr_ie = wr_acc & sel_ie;
  wire wr_tg = wr_acc & sel_tg;

  // Software registers
  logic [7:0] modem_control_reg_q;
  logic [7:0] int_en_q;
  logic [6:0] rx_trig_q;
  logic [7:0] tx_hold_q;
  logic tx_pend_q;

  wire loop_on = modem_control_reg_q[uspm_pkg::MC_LOOP];
  wire auto_flow = modem_control_reg_q[uspm_pkg::MC_AUTO_FLOW];
  wire ir_on = modem_control_reg_q[uspm_pkg::MC_IR];

  // Modem inputs as seen by status; loopback feeds control bits back
  wire cts_act = loop_on ? modem_control_reg_q[uspm_pkg::MC_RTS]
                         : ~cts_n_s_q; // RQ12
  wire dsr_act = loop_on ? modem_control_reg_q[uspm_pkg::MC_DTR]
                         : ~dsr_n_s_q; // RQ16

  // Set wins over the read clear, so a change in the clearing cycle is kept
  function automatic logic flag_next(input logic chg, input logic flag,
                                     input logic clr);
    flag_next = chg | (flag & ~clr);
  endfunction

  logic cts_prev_q, dsr_prev_q;
  logic dcts_q, ddsr_q;
  wire cts_chg = cts_act ^ cts_prev_q;
  wire dsr_chg = dsr_act ^ dsr_prev_q;
  wire ms_clr = rd_acc & sel_ms;

  // Unused status bits read as zero
  wire [7:0] modem_status_reg = {2'b00, dsr_act, cts_act,
                                 2'b00, ddsr_q, dcts_q};

  // Transmitter link
  uspm_tx_if tx_ifc ();

  // Under auto flow a new character waits while clear-to-send is inactive
  wire tx_gate = ~auto_flow | cts_act; // RQ15 RQ20
  assign tx_ifc.start = tx_pend_q & tx_gate; // RQ20
  assign tx_ifc.data = tx_hold_q;
  assign tx_ifc.ir_mode = ir_on;

  uspm_tx #(
    .CLKS_PER_BIT(CLKS_PER_BIT)
  ) u_tx (
    .clk(CLK_SYS),
    .rst(RST),
    .ifc(tx_ifc)
  );

  wire tx_taken = tx_ifc.start & tx_ifc.ready;
  // Busy covers a held character as well as the frame on the line
  wire tx_busy = tx_pend_q | ~tx_ifc.ready;

  // Request-to-send active below the trigger level under auto flow
  wire below_trig = RX_FIFO_LEVEL < rx_trig_q;
  wire rts_on = modem_control_reg_q[uspm_pkg::MC_RTS]
                & (~auto_flow | below_trig); // RQ6 RQ7
  wire dtr_on = modem_control_reg_q[uspm_pkg::MC_DTR]; // RQ10
  wire rts_n_d = loop_on | ~rts_on; // RQ9
  wire dtr_n_d = loop_on | ~dtr_on; // RQ9
  wire idle_level = ~ir_on; // RQ1 RQ2
  // Loopback keeps the line at its idle level
  wire tx_pin_d = loop_on ? idle_level : tx_ifc.line;

  wire [7:0] line_stat = {5'h00, SERIAL_TX_OUT, rx_s_q, tx_busy};

  // Unmapped and write-only offsets read as zero
  logic [7:0] rd_sel;
  always_comb
  begin
    rd_sel = 8'h00;
    case (1'b1)
      sel_mc: rd_sel = modem_control_reg_q;
      sel_ms: rd_sel = modem_status_reg;
      sel_ie: rd_sel = int_en_q;
      sel_tg: rd_sel = {1'b0, rx_trig_q};
      sel_ls: rd_sel = line_stat;
      default: rd_sel = 8'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ack_q <= 1'b0;
      AVS_READDATA <= '0;
    end
    else
    begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q)
        AVS_READDATA <= {24'h000000, rd_sel};
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      modem_control_reg_q <= uspm_pkg::MC_RESET; // RQ3
    else if (wr_mc)
      modem_control_reg_q <= AVS_WRITEDATA[7:0] & uspm_pkg::MC_MASK;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      int_en_q <= 8'h00;
    else if (wr_ie)
      int_en_q <= AVS_WRITEDATA[7:0];
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      rx_trig_q <= uspm_pkg::RX_TRIG_RESET;
    else if (wr_tg)
      rx_trig_q <= AVS_WRITEDATA[6:0];
  end

  // Holding register; a write while one is pending is dropped
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      tx_hold_q <= 8'h00;
      tx_pend_q <= 1'b0;
    end
    else if (wr_acc && sel_tx && !tx_pend_q)
    begin
      tx_hold_q <= AVS_WRITEDATA[7:0];
      tx_pend_q <= 1'b1;
    end
    else if (tx_taken)
      tx_pend_q <= 1'b0;
  end

  // Change flags: a change in the clearing cycle survives the read
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      cts_prev_q <= 1'b0;
      dsr_prev_q <= 1'b0;
      dcts_q <= 1'b0;
      ddsr_q <= 1'b0;
    end
    else
    begin
      cts_prev_q <= cts_act;
      dsr_prev_q <= dsr_act;
      dcts_q <= flag_next(cts_chg, dcts_q, ms_clr); // RQ13 RQ19
      ddsr_q <= flag_next(dsr_chg, ddsr_q, ms_clr); // RQ17 RQ19
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      RTS_N <= 1'b1; // RQ8
    else
      RTS_N <= rts_n_d;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      DTR_N <= 1'b1; // RQ11
    else
      DTR_N <= dtr_n_d;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      SERIAL_TX_OUT <= 1'b1; // RQ3
    else
      SERIAL_TX_OUT <= tx_pin_d;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      MODEM_IRQ <= 1'b0;
    else
      MODEM_IRQ <= int_en_q[uspm_pkg::IE_MODEM]
                   & (dcts_q | ddsr_q); // RQ14 RQ18
  end
endmodule // uart_serial_modem_pins

// File: verif/uspm_asserts.sv
// Port-level checks of the serial and modem pin block
`timescale 1ns/1ps
module uspm_asserts #(
  parameter int unsigned CLKS_PER_BIT = 4
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [4:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic SERIAL_TX_OUT,
  input wire logic SERIAL_RX_IN,
  input wire logic RTS_N,
  input wire logic DTR_N,
  input wire logic CTS_N,
  input wire logic DSR_N,
  input wire logic [6:0] RX_FIFO_LEVEL,
  input wire logic MODEM_IRQ
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire ctl_w = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0]
    && AVS_ADDRESS == 5'h04;
  wire req_w = AVS_READ || AVS_WRITE;
  reset_pins_a: assert property ($fell(RST) |->
    SERIAL_TX_OUT && RTS_N && DTR_N) else $error("pins not idle");
  one_wait_a: assert property ($rose(req_w) |->
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("wait count");
  rdata_hi_a: assert property (AVS_READ && !AVS_WAITREQUEST |->
    AVS_READDATA[31:8] == 24'h000000) else $error("upper data");
  rts_ctrl_a: assert property (ctl_w && !AVS_WRITEDATA[4]
    && !AVS_WRITEDATA[5] |-> ##2 RTS_N == !$past(AVS_WRITEDATA[1], 2))
    else $error("rts level");
  dtr_ctrl_a: assert property (ctl_w && !AVS_WRITEDATA[4] |-> ##2
    DTR_N == !$past(AVS_WRITEDATA[0], 2)) else $error("dtr level");
  loop_force_a: assert property (ctl_w && AVS_WRITEDATA[4] |-> ##2
    RTS_N && DTR_N) else $error("loop outputs");
  irq_clear_a: assert property ($fell(MODEM_IRQ) && !$past(RST) |->
    $past(req_w, 2)) else $error("irq dropped");
  irq_cause_a: assert property ($rose(MODEM_IRQ) |->
    $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)
    || $past(CTS_N, 4) != $past(CTS_N, 5)
    || $past(DSR_N, 4) != $past(DSR_N, 5)) else $error("irq cause");
  cover property ($rose(MODEM_IRQ));
  cover property (ctl_w && AVS_WRITEDATA[4]);
  cover property ($fell(SERIAL_TX_OUT));
endmodule // uspm_asserts

// File: verif/uspm_modem.sv
// Remote modem model on the handshake and receive lines
`timescale 1ns/1ps
module uspm_modem (
  input wire logic cts_on,
  input wire logic dsr_on,
  input wire logic ir_mode,
  output logic cts_n,
  output logic dsr_n,
  output logic rx_line
);
  assign cts_n = !cts_on;
  assign dsr_n = !dsr_on;
  // Sends no frames, so the line rests at the mode's idle level
  assign rx_line = !ir_mode;
endmodule // uspm_modem

// File: verif/testbench.sv
// Self-checking bench for the serial and modem pin block
`timescale 1ns/1ps
module testbench;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'h0;
  logic wr = 1'h0;
  logic [31:0] wd = 32'h0;
  logic [6:0] lvl = 7'h00;
  logic cts_on = 1'h0;
  logic dsr_on = 1'h0;
  logic ir = 1'h0;
  logic [31:0] rdat, q;
  logic wait_r, tx, rts_n, dtr_n, irq, cts_n, dsr_n, rx;
  int errors = 0;
  int comparisons = 0;
  initial forever #12.5 clk = ~clk;
  uspm_modem partner (.cts_on(cts_on), .dsr_on(dsr_on), .ir_mode(ir),
    .cts_n(cts_n), .dsr_n(dsr_n), .rx_line(rx));
  uart_serial_modem_pins #(.CLKS_PER_BIT(4)) dut (.CLK_SYS(clk),
    .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wait_r), .SERIAL_TX_OUT(tx), .SERIAL_RX_IN(rx),
    .RTS_N(rts_n), .DTR_N(dtr_n), .CTS_N(cts_n), .DSR_N(dsr_n),
    .RX_FIFO_LEVEL(lvl), .MODEM_IRQ(irq));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a,
    input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
      @(posedge clk);
    while (wait_r);
    q = rdat;
    wr <= 1'h0;
    rd <= 1'h0;
  endtask
  task automatic t_reset;
    chk("tx", 32'h1, tx);
    chk("rts", 32'h1, rts_n);
    chk("dtr", 32'h1, dtr_n);
    bus(1'h0, 5'h04, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(1'h0, 5'h18, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_ctrl;
    bus(1'h1, 5'h04, 32'h3);
    cyc(2);
    @(negedge clk);
    chk("rts on", 32'h0, rts_n);
    chk("dtr on", 32'h0, dtr_n);
    bus(1'h1, 5'h04, 32'h13);
    cyc(2);
    @(negedge clk);
    chk("rts loop", 32'h1, rts_n);
    chk("dtr loop", 32'h1, dtr_n);
    bus(1'h1, 5'h04, 32'h0);
    cyc(6);
    bus(1'h0, 5'h08, 32'h0);
    chk("rts off", 32'h1, rts_n);
    chk("dtr off", 32'h1, dtr_n);
  endtask
  task automatic t_status;
    bus(1'h1, 5'h0C, 32'h8);
    cts_on <= 1'h1;
    cyc(6);
    @(negedge clk);
    chk("irq cts", 32'h1, irq);
    bus(1'h0, 5'h08, 32'h0);
    chk("stat cts", 32'h11, q);
    bus(1'h0, 5'h08, 32'h0);
    chk("stat read", 32'h10, q);
    @(negedge clk);
    chk("irq clr", 32'h0, irq);
    cyc(1);
    dsr_on <= 1'h1;
    cyc(6);
    @(negedge clk);
    chk("irq dsr", 32'h1, irq);
    bus(1'h0, 5'h08, 32'h0);
    chk("stat dsr", 32'h32, q);
  endtask
  task automatic t_ir;
    bus(1'h1, 5'h04, 32'h40);
    ir <= 1'h1;
    cyc(4);
    @(negedge clk);
    chk("ir idle", 32'h0, tx);
    bus(1'h0, 5'h14, 32'h0);
    chk("rx ir", 32'h0, q[1]);
    bus(1'h1, 5'h04, 32'h0);
    ir <= 1'h0;
    cyc(4);
    @(negedge clk);
    chk("tx idle", 32'h1, tx);
    bus(1'h0, 5'h14, 32'h0);
    chk("rx idle", 32'h1, q[1]);
  endtask
  task automatic t_frame;
    logic [9:0] f;
    int n;
    f = {1'h1, 8'hA5, 1'h0};
    n = 0;
    bus(1'h1, 5'h00, 32'hA5);
    while (tx && n < 40)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    for (int i = 0; i < 10; i++)
    begin
      chk("frame bit", f[i], tx);
      repeat (4) @(negedge clk);
    end
  endtask
  task automatic t_auto;
    logic held;
    held = 1'h1;
    cyc(1);
    cts_on <= 1'h0;
    cyc(6);
    bus(1'h0, 5'h08, 32'h0);
    bus(1'h1, 5'h04, 32'h22);
    cyc(2);
    @(negedge clk);
    chk("rts auto low", 32'h0, rts_n);
    cyc(1);
    lvl <= 7'h08;
    cyc(2);
    @(negedge clk);
    chk("rts auto full", 32'h1, rts_n);
    bus(1'h1, 5'h00, 32'h5A);
    repeat (40) @(negedge clk) if (!tx) held = 1'h0;
    chk("tx held", 32'h1, held);
    cyc(1);
    cts_on <= 1'h1;
    repeat (20) @(negedge clk) if (!tx) held = 1'h0;
    chk("tx sent", 32'h0, held);
    cyc(50);
  endtask
  task automatic end_of_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    cyc(5000);
    errors++;
    end_of_test;
  end
  initial
  begin
    cyc(20);
    rst <= 1'h0;
    cyc(2);
    @(negedge clk);
    t_reset;
    t_ctrl;
    t_status;
    t_ir;
    t_frame;
    t_auto;
    end_of_test;
  end
endmodule // testbench
bind uart_serial_modem_pins uspm_asserts #(.CLKS_PER_BIT(CLKS_PER_BIT))
  chk_i (.CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .SERIAL_TX_OUT(SERIAL_TX_OUT), .SERIAL_RX_IN(SERIAL_RX_IN),
  .RTS_N(RTS_N), .DTR_N(DTR_N), .CTS_N(CTS_N), .DSR_N(DSR_N),
  .RX_FIFO_LEVEL(RX_FIFO_LEVEL), .MODEM_IRQ(MODEM_IRQ));
